/* i2ctr_map.vh */
// i2ctr_map.vh: constants for the ten-bit i2c slave receiver
// assumes: included by bare name from the design files
`ifndef I2CTR_MAP_VH
`define I2CTR_MAP_VH
// ===========================================
// address byte layout
`define I2CTR_PREFIX_MSB     7
`define I2CTR_PREFIX_LSB     3
`define I2CTR_PREFIX_VAL     5'h1e
`define I2CTR_HIADDR_MSB     2
`define I2CTR_HIADDR_LSB     1
`define I2CTR_RW_BIT         0
// ===========================================
// reset values
`define I2CTR_BYTE_RST       8'h00
`define I2CTR_CNT_RST        4'h0
// ===========================================
// bit counts
`define I2CTR_ACK_BIT        4'h8
`define I2CTR_LAST_BIT       4'h9
`endif

/* i2ctr_skid_buf.v */
// i2ctr_skid_buf.v: two-entry valid/ready buffer for received bytes
// assumes: source and sink run on the same clock as the buffer
`timescale 1ns/1ps
module i2ctr_skid_buf #(
   parameter WIDTH = 8,
   parameter DEPTH = 2
) (
   input  wire             ref_clk,   // system clock
   input  wire             rstn,      // async reset, active low
   input  wire [WIDTH-1:0] inData,    // word from source
   input  wire             inValid,   // source has a word
   output wire             inReady,   // buffer can take a word
   output wire [WIDTH-1:0] outData,   // head word
   output wire             outValid,  // head word present
   input  wire             outReady   // sink takes head word
);
   // ===========================================
   // storage and pointers
   reg [WIDTH-1:0] mem [0:DEPTH-1];   // word store
   reg             wrPtr_reg;         // write pointer
   reg             rdPtr_reg;         // read pointer
   reg [1:0]       count_reg;         // words held
   wire            doWrite;           // accepted push
   wire            doRead;            // accepted pop
   assign inReady  = (count_reg != 2'd2);
   assign outValid = (count_reg != 2'd0);
   assign outData  = mem[rdPtr_reg];
   assign doWrite  = inValid & inReady;
   assign doRead   = outValid & outReady;
   // store the word
   always @(posedge ref_clk) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end
   // pointer and count update
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'd0;
      end else begin
         if (doWrite) begin
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (doRead) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         if (doWrite & ~doRead) begin
            count_reg <= count_reg + 2'd1;
         end else if (doRead & ~doWrite) begin
            count_reg <= count_reg - 2'd1;
         end
      end
   end
endmodule

/* i2ctr_slave_rx.v */
// i2ctr_slave_rx.v: i2c target receiver with ten-bit addressing and stretch
// assumes: scl/sda arrive from pins, bus clock slow against ref_clk;
//          software side is a plain flag/strobe interface on ref_clk
`timescale 1ns/1ps
`include "i2ctr_map.vh"
module i2ctr_slave_rx (
   input  wire       ref_clk,          // system clock, 25 MHz
   input  wire       rstn,             // async reset, active low
   input  wire       sclIn,            // serial_clock_line pin level
   output reg        sclOut,           // clock pin drive value (low)
   output reg        sclOe,            // clock pin drive enable
   input  wire       sdaIn,            // data pin level
   output reg        sdaOut,           // data pin drive value (low)
   output reg        sdaOe,            // data pin drive enable
   input  wire [7:0] ownAddrWrData,    // own_address_reg write data
   input  wire       ownAddrWr,        // own_address_reg write strobe
   input  wire       startIrqEn,       // irq on start enable
   input  wire       stretchEnable,    // stretch_enable bit
   input  wire       addrHoldEn,       // addr_hold_en bit
   input  wire       dataHoldEn,       // data_hold_en bit
   input  wire       clockReleaseSet,  // software sets clock_release
   input  wire       irqFlagClr,       // software clears port_irq_flag
   input  wire       bufRead,          // rx_tx_buffer read strobe
   output reg  [7:0] rxBuffer,         // rx_tx_buffer contents
   output reg        bufferFull,       // buffer_full flag
   output reg        portIrqFlag,      // port_irq_flag
   output reg        addrUpdateReq,    // addr_update_req flag
   output reg        startSeen,        // start status bit
   output reg        stopSeen,         // stop status bit
   output reg        clockRelease,     // clock_release bit
   output reg  [7:0] ownAddress        // own_address_reg readback
);
   // ===========================================
   // states
   localparam ST_IDLE = 3'd0;  // waiting for start
   localparam ST_HIGH = 3'd1;  // high address byte
   localparam ST_LOW  = 3'd2;  // low address byte
   localparam ST_DATA = 3'd3;  // data bytes
   localparam ST_SKIP = 3'd4;  // not addressed, wait stop
   // ST_SKIP ignores bits until the next start or stop
   // ===========================================
   // synchronisers and edges
   reg  [1:0] sclSync_reg;      // scl two-stage sync
   reg  [1:0] sdaSync_reg;      // sda two-stage sync
   reg        sclPrev_reg;      // scl last sample
   reg        sdaPrev_reg;      // sda last sample
   wire       sclRise;          // scl rising
   wire       sclFall;          // scl falling
   wire       startEv;          // start or repeated start
   wire       stopEv;           // stop
   // protocol state
   reg  [2:0] state_reg;        // protocol state
   reg  [3:0] bitCnt_reg;       // bits of current byte
   reg  [7:0] shift_reg;        // incoming byte
   reg        ackPend_reg;      // ack due on ninth pulse
   reg        isAddr_reg;       // byte in flight is address
   reg        stretch_reg;      // hold clock low
   reg        lowPend_reg;      // stretch waiting for address write
   reg        byteDone_reg;     // one-cycle byte complete pulse
   reg  [7:0] doneByte_reg;     // byte just completed
   reg        doneMatch_reg;    // completed byte matched
   reg        doneData_reg;     // completed byte is data
   // buffer link
   wire [7:0] bufOutData;       // head byte
   wire       bufOutValid;      // head present
   wire       bufInReady;       // buffer has space
   wire       bufPop;           // move head into rxBuffer
   wire       hiMatch;          // high byte address compare
   wire       loMatch;          // low byte compare
   // ===========================================
   // pin sampling
   // two flops per pin before any logic reads the level
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclSync_reg <= 2'b11;
         sdaSync_reg <= 2'b11;
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclSync_reg <= {sclSync_reg[0], sclIn};
         sdaSync_reg <= {sdaSync_reg[0], sdaIn};
         sclPrev_reg <= sclSync_reg[1];
         sdaPrev_reg <= sdaSync_reg[1];
      end
   end
   // edges from the synchronised level against its last sample
   assign sclRise = sclSync_reg[1] & ~sclPrev_reg;
   assign sclFall = ~sclSync_reg[1] & sclPrev_reg;
   // start: data falls with clock high; stop: data rises
   assign startEv = sclSync_reg[1] & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg[1];
   assign stopEv  = sclSync_reg[1] & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg[1];
   // ===========================================
   // address compare on the assembled byte
   // prefix, two upper bits, write direction
   assign hiMatch = (shift_reg[`I2CTR_PREFIX_MSB:`I2CTR_PREFIX_LSB] == `I2CTR_PREFIX_VAL)
                  & (shift_reg[`I2CTR_HIADDR_MSB:`I2CTR_HIADDR_LSB]
                     == ownAddress[`I2CTR_HIADDR_MSB:`I2CTR_HIADDR_LSB])
                  & ~shift_reg[`I2CTR_RW_BIT];
   // low byte needs all eight bits of the own address
   assign loMatch = (shift_reg == ownAddress);
   // ===========================================
   // bus protocol engine
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= ST_IDLE;
         bitCnt_reg    <= `I2CTR_CNT_RST;
         shift_reg     <= `I2CTR_BYTE_RST;
         ackPend_reg   <= 1'b0;
         isAddr_reg    <= 1'b0;
         byteDone_reg  <= 1'b0;
         doneByte_reg  <= `I2CTR_BYTE_RST;
         doneMatch_reg <= 1'b0;
         doneData_reg  <= 1'b0;
         sdaOut        <= 1'b0;
         sdaOe         <= 1'b0;
      end else begin
         byteDone_reg <= 1'b0;
         // pin values stay low; only the enables move
         sdaOut       <= 1'b0;
         if (startEv) begin
            // fresh address phase on start
            state_reg   <= ST_HIGH;
            bitCnt_reg  <= `I2CTR_CNT_RST;
            ackPend_reg <= 1'b0;
            sdaOe       <= 1'b0;
         end else if (stopEv) begin
            // stop ends the transfer
            state_reg   <= ST_IDLE;
            bitCnt_reg  <= `I2CTR_CNT_RST;
            ackPend_reg <= 1'b0;
            sdaOe       <= 1'b0;
         end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
            if (sclRise && bitCnt_reg < `I2CTR_ACK_BIT) begin
               // sample a data bit, msb first
               shift_reg  <= {shift_reg[6:0], sdaSync_reg[1]};
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclRise && bitCnt_reg == `I2CTR_ACK_BIT) begin
               // ninth pulse high: ack being sampled by master
               bitCnt_reg <= `I2CTR_LAST_BIT;
            end else if (sclFall && bitCnt_reg == `I2CTR_ACK_BIT) begin
               // eighth falling edge: byte complete, decide ack
               byteDone_reg  <= 1'b1;
               doneByte_reg  <= shift_reg;
               doneData_reg  <= (state_reg == ST_DATA);
               isAddr_reg    <= (state_reg != ST_DATA);
               // remember whether the byte belongs to us
               case (state_reg)
                  ST_HIGH: doneMatch_reg <= hiMatch;
                  ST_LOW:  doneMatch_reg <= loMatch;
                  ST_DATA: doneMatch_reg <= 1'b1;
                  default: doneMatch_reg <= 1'b0;
               endcase
               case (state_reg)
                  // ack only matched addresses and data
                  ST_HIGH: sdaOe <= hiMatch;
                  ST_LOW:  sdaOe <= loMatch;
                  default: sdaOe <= 1'b1;
               endcase
               case (state_reg)
                  ST_HIGH: ackPend_reg <= hiMatch;
                  ST_LOW:  ackPend_reg <= loMatch;
                  default: ackPend_reg <= 1'b1;
               endcase
            end else if (sclFall && bitCnt_reg == `I2CTR_LAST_BIT) begin
               // ninth pulse over: release data, next byte
               // a refused address parks the engine in ST_SKIP
               sdaOe       <= 1'b0;
               ackPend_reg <= 1'b0;
               bitCnt_reg  <= `I2CTR_CNT_RST;
               case (state_reg)
                  ST_HIGH: state_reg <= ackPend_reg ? ST_LOW : ST_SKIP;
                  ST_LOW:  state_reg <= ackPend_reg ? ST_DATA : ST_SKIP;
                  ST_DATA: state_reg <= ST_DATA;
                  default: state_reg <= ST_SKIP;
               endcase
            end
         end
      end
   end
   // ===========================================
   // received byte buffering; a matched byte that finds the buffer full
   // is dropped, which the stretch mechanism prevents in normal use
   // (bufInReady is left for observation only)
   i2ctr_skid_buf #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_buf (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .inData   (doneByte_reg),
      .inValid  (byteDone_reg & doneMatch_reg),
      .inReady  (bufInReady),
      .outData  (bufOutData),
      .outValid (bufOutValid),
      .outReady (bufPop)
   );
   // head moves to software view once previous byte was read
   assign bufPop = bufOutValid & (~bufferFull | bufRead);
   // ===========================================
   // software-visible flags
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxBuffer      <= `I2CTR_BYTE_RST;
         bufferFull    <= 1'b0;
         portIrqFlag   <= 1'b0;
         addrUpdateReq <= 1'b0;
         startSeen     <= 1'b0;
         stopSeen      <= 1'b0;
         clockRelease  <= 1'b1;
         ownAddress    <= `I2CTR_BYTE_RST;
         stretch_reg   <= 1'b0;
         lowPend_reg   <= 1'b0;
      end else begin
         // own address write, ends address stretch
         if (ownAddrWr) begin
            ownAddress  <= ownAddrWrData;
            lowPend_reg <= 1'b0;
         end
         // buffer full: set by pop wins over read clear
         if (bufPop) begin
            rxBuffer   <= bufOutData;
            bufferFull <= 1'b1;
         end else if (bufRead) begin
            bufferFull <= 1'b0;
         end
         // start and stop status
         if (startEv) begin
            startSeen <= 1'b1;
            stopSeen  <= 1'b0;
         end else if (stopEv) begin
            startSeen <= 1'b0;
            stopSeen  <= 1'b1;
         end
         // interrupt flag: any set beats software clear; a foreign
         // high byte raises nothing, a low mismatch still interrupts
         if ((startEv & startIrqEn)
             | (byteDone_reg & (doneMatch_reg | (isAddr_reg & (state_reg == ST_LOW))))) begin
            portIrqFlag <= 1'b1;
         end else if (irqFlagClr) begin
            portIrqFlag <= 1'b0;
         end
         // address update request, raised after a matched high byte and after every low byte
         // state still names the byte's phase here: the low byte raises it
         // even on mismatch so software can restore the high address
         if (byteDone_reg & ~doneData_reg & (doneMatch_reg | (state_reg == ST_LOW))) begin
            addrUpdateReq <= 1'b1;
         end else if (ownAddrWr) begin
            addrUpdateReq <= 1'b0;
         end
         // clock_release: data stretch clears it, mismatch leaves it
         if (byteDone_reg & doneData_reg & (stretchEnable | dataHoldEn)) begin
            clockRelease <= 1'b0;
         end else if (byteDone_reg & ~doneData_reg & doneMatch_reg & addrHoldEn) begin
            clockRelease <= 1'b0;
         end else if (clockReleaseSet) begin
            clockRelease <= 1'b1;
         end
         // high address matched: wait for software address reload
         if (byteDone_reg & ~doneData_reg & doneMatch_reg & (state_reg == ST_HIGH)) begin
            lowPend_reg <= 1'b1;
         end
         if (startEv | stopEv) begin
            lowPend_reg <= 1'b0;
         end
         // registered so the clock drive sees one clean request
         stretch_reg <= lowPend_reg | ~clockRelease;
      end
   end
   // ===========================================
   // clock line drive: hold low during ack-end low phase when stretching
   // only pulled while the wire already reads low, so no high phase is cut
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
      end else begin
         sclOut <= 1'b0;
         if (stopEv | startEv) begin
            sclOe <= 1'b0;
         end else if (stretch_reg & ~sclSync_reg[1] & (bitCnt_reg == `I2CTR_CNT_RST)
                      & (state_reg != ST_IDLE) & (state_reg != ST_SKIP)) begin
            sclOe <= 1'b1;
         end else if (~stretch_reg) begin
            sclOe <= 1'b0;
         end
      end
   end
endmodule

/* i2ctr_slave_rx_monitor.sv */
// i2ctr_slave_rx_monitor.sv: port assertions for the ten-bit i2c receiver
// assumes: bound to i2ctr_slave_rx, everything on ref_clk
`timescale 1ns/1ps
module i2ctr_slave_rx_monitor (
   input wire       ref_clk,          // system clock
   input wire       rstn,             // reset, active low
   input wire       sclIn,            // clock wire level
   input wire       sclOe,            // clock pull enable
   input wire       sdaOe,            // data pull enable
   input wire [7:0] ownAddrWrData,    // address write data
   input wire       ownAddrWr,        // address write strobe
   input wire       startIrqEn,       // irq on start
   input wire       stretchEnable,    // data stretch
   input wire       addrHoldEn,       // address hold
   input wire       dataHoldEn,       // data hold
   input wire       clockReleaseSet,  // release strobe
   input wire       portIrqFlag,      // irq flag
   input wire       addrUpdateReq,    // update request
   input wire       startSeen,        // start status
   input wire       clockRelease,     // release bit
   input wire [7:0] ownAddress        // address readback
);
   // ==========================================
   // single domain defaults
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // assertions
   start_irq_a: assert property ($rose(startSeen) && startIrqEn |-> ##[0:2] portIrqFlag)
      else $error("start seen without irq flag");
   upd_irq_a: assert property ($rose(addrUpdateReq) |-> ##[0:2] portIrqFlag)
      else $error("update request without irq flag");
   upd_hold_a: assert property (addrUpdateReq && !ownAddrWr |=> addrUpdateReq)
      else $error("update request dropped by itself");
   addr_load_a: assert property (ownAddrWr |=> ownAddress == $past(ownAddrWrData))
      else $error("own address not loaded");
   rel_set_a: assert property (clockReleaseSet |-> ##[1:2] clockRelease)
      else $error("release strobe ignored");
   rel_clear_a: assert property ($fell(clockRelease) |-> stretchEnable || addrHoldEn || dataHoldEn)
      else $error("release cleared with no hold mode");
   ack_low_a: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("ack driven while clock high");
   stretch_low_a: assert property ($rose(sclOe) |-> !sclIn)
      else $error("stretch begun while clock high");
endmodule
bind i2ctr_slave_rx i2ctr_slave_rx_monitor i2ctr_slave_rx_monitor_i (
   .ref_clk(ref_clk), .rstn(rstn), .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe),
   .ownAddrWrData(ownAddrWrData), .ownAddrWr(ownAddrWr), .startIrqEn(startIrqEn),
   .stretchEnable(stretchEnable), .addrHoldEn(addrHoldEn), .dataHoldEn(dataHoldEn),
   .clockReleaseSet(clockReleaseSet), .portIrqFlag(portIrqFlag),
   .addrUpdateReq(addrUpdateReq), .startSeen(startSeen), .clockRelease(clockRelease),
   .ownAddress(ownAddress));

/* i2ctr_master_model.sv */
// i2ctr_master_model.sv: behavioural i2c bus master, 320 ns bit period
// assumes: open-drain wires with pull-ups, levels fed back on sclLine/sdaLine
`timescale 1ns/1ps
module i2ctr_master_model (
   input  wire sclLine,  // clock wire level
   input  wire sdaLine,  // data wire level
   output reg  sclDrv,   // pulls clock low
   output reg  sdaDrv,   // pulls data low
   output reg  stuck     // stretch wait ran out
);
   initial begin
      sclDrv = 1'b0;
      sdaDrv = 1'b0;
      stuck = 1'b0;
   end
   // ==========================================
   // release clock, wait out any stretch, bounded
   task clk_high;
      integer n;
      begin
         n = 0;
         sclDrv = 1'b0;
         // once stuck, later waits return at once so the run still ends
         while (sclLine !== 1'b1 && n < 500 && !stuck) begin
            #40;
            n = n + 1;
         end
         if (n >= 500) stuck = 1'b1;
      end
   endtask
   // data falls while clock high
   task bus_start;
      begin
         sdaDrv = 1'b1;
         #120;
         sclDrv = 1'b1;
      end
   endtask
   // msb first, then ninth pulse samples ack
   task send_byte(input [7:0] b, output reg ackSeen);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            #80;
            sdaDrv = ~b[i];
            #120;
            clk_high;
            #120;
            sclDrv = 1'b1;
         end
         #80;
         sdaDrv = 1'b0;
         #120;
         clk_high;
         ackSeen = ~sdaLine;
         #120;
         sclDrv = 1'b1;
      end
   endtask
   // data rises while clock high, ends the transfer
   task bus_stop;
      begin
         #80;
         sdaDrv = 1'b1;
         #120;
         clk_high;
         #120;
         sdaDrv = 1'b0;
      end
   endtask
endmodule

/* test_i2ctr_slave_rx.sv */
// test_i2ctr_slave_rx.sv: self-checking bench for the ten-bit i2c receiver
// assumes: master model on the bus, pull-ups on both wires
`timescale 1ns/1ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
   n_errors = n_errors + 1; $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
   end end
module test_i2ctr_slave_rx;
   localparam [7:0] HI = 8'hf2;  // prefix, upper bits 01, write
   localparam [7:0] LO = 8'h5a;  // low address byte
   reg        ref_clk, rstn, ownAddrWr, startIrqEn, stretchEnable;  // clock, controls
   reg        addrHoldEn, dataHoldEn, clockReleaseSet, irqFlagClr, bufRead;  // controls
   reg  [7:0] ownAddrWrData;                                        // address data
   reg        ack;                                                  // last ack seen
   integer    n_errors, checked, k;                                 // counters
   wire [7:0] rxBuffer, ownAddress;                                 // byte outputs
   wire       sclOut, sclOe, sdaOut, sdaOe, mScl, mSda, stuck;      // pin drives
   wire       bufferFull, portIrqFlag, addrUpdateReq;               // flags
   wire       startSeen, stopSeen, clockRelease;                    // status
   wire       sclWire = ~((sclOe & ~sclOut) | mScl);                // pulled-up clock
   wire       sdaWire = ~((sdaOe & ~sdaOut) | mSda);                // pulled-up data
   i2ctr_slave_rx i2ctr_slave_rx_i (
      .ref_clk(ref_clk), .rstn(rstn), .sclIn(sclWire), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .ownAddrWrData(ownAddrWrData),
      .ownAddrWr(ownAddrWr), .startIrqEn(startIrqEn), .stretchEnable(stretchEnable),
      .addrHoldEn(addrHoldEn), .dataHoldEn(dataHoldEn), .clockReleaseSet(clockReleaseSet),
      .irqFlagClr(irqFlagClr), .bufRead(bufRead), .rxBuffer(rxBuffer),
      .bufferFull(bufferFull), .portIrqFlag(portIrqFlag), .addrUpdateReq(addrUpdateReq),
      .startSeen(startSeen), .stopSeen(stopSeen), .clockRelease(clockRelease),
      .ownAddress(ownAddress));
   i2ctr_master_model i2ctr_master_model_i (.sclLine(sclWire), .sdaLine(sdaWire),
      .sclDrv(mScl), .sdaDrv(mSda), .stuck(stuck));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // ==========================================
   // software side tasks
   task settle(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   // strobes {release set, buffer read, irq clear}
   task sw(input [2:0] s);
      begin
         @(posedge ref_clk);
         {clockReleaseSet, bufRead, irqFlagClr} <= s;
         @(posedge ref_clk);
         {clockReleaseSet, bufRead, irqFlagClr} <= 3'h0;
         settle(4);
      end
   endtask
   task service;  // irq cleared before the byte is read
      begin
         sw(3'h1);
         sw(3'h2);
      end
   endtask
   task wr_addr(input [7:0] a);
      begin
         @(posedge ref_clk);
         ownAddrWrData <= a;
         ownAddrWr <= 1'b1;
         @(posedge ref_clk);
         ownAddrWr <= 1'b0;
         settle(4);
      end
   endtask
   task byte_out(input [7:0] b);
      begin
         i2ctr_master_model_i.send_byte(b, ack);
         settle(8);
      end
   endtask
   // start, high byte, low address load, low byte
   task open_frame(input [7:0] lo);
      begin
         i2ctr_master_model_i.bus_start;
         settle(8);
         `CHK(startSeen, 1'b1)
         `CHK(portIrqFlag, startIrqEn)
         sw(3'h1);
         byte_out(HI);
         `CHK(ack, 1'b1)
         `CHK(portIrqFlag, 1'b1)
         `CHK(addrUpdateReq, 1'b1)
         `CHK(sclOe, 1'b1)
         service;
         `CHK(bufferFull, 1'b0)
         wr_addr(LO);
         `CHK(sclOe, 1'b0)
         byte_out(lo);
         `CHK(portIrqFlag, 1'b1)
         `CHK(addrUpdateReq, 1'b1)
      end
   endtask
   task stop_bus;
      begin
         i2ctr_master_model_i.bus_stop;
         settle(8);
      end
   endtask
   task wrap_up;
      begin
         $display("errors %0d, checks %0d", n_errors, checked);
         if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
         end else begin
            $display("Test failed");
         end
         $finish;
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      rstn = 1'b0;
      {ownAddrWr, startIrqEn, stretchEnable, addrHoldEn} = 4'h0;
      {dataHoldEn, clockReleaseSet, irqFlagClr, bufRead} = 4'h0;
      ownAddrWrData = 8'h00;
      ack = 1'b0;
      n_errors = 0;
      checked = 0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      settle(3);
      `CHK(clockRelease, 1'b1)
      `CHK(ownAddress, 8'h00)
      startIrqEn <= 1'b1;
      stretchEnable <= 1'b1;
      wr_addr(HI);
      open_frame(LO);
      service;
      wr_addr(HI);
      for (k = 0; k < 2; k = k + 1) begin
         byte_out(8'ha5 ^ k[7:0]);
         `CHK(ack, 1'b1)
         `CHK(rxBuffer, 8'ha5 ^ k[7:0])
         `CHK(clockRelease, 1'b0)
         `CHK(sclOe, 1'b1)
         service;
         sw(3'h4);
         `CHK(sclOe, 1'b0)
      end
      stop_bus;
      `CHK(stopSeen, 1'b1)
      startIrqEn <= 1'b0;
      open_frame(LO ^ 8'h01);
      `CHK(bufferFull, 1'b0)
      `CHK(clockRelease, 1'b1)
      wr_addr(HI);
      sw(3'h1);
      stop_bus;
      i2ctr_master_model_i.bus_start;
      settle(8);
      byte_out(8'hf6);
      `CHK(ack, 1'b0)
      `CHK(addrUpdateReq, 1'b0)
      `CHK(portIrqFlag, 1'b0)
      stop_bus;
      stretchEnable <= 1'b0;
      open_frame(LO);
      service;
      wr_addr(HI);
      byte_out(8'h3c);
      byte_out(8'hc3);
      `CHK(rxBuffer, 8'h3c)
      sw(3'h2);
      `CHK(rxBuffer, 8'hc3)
      sw(3'h2);
      `CHK(bufferFull, 1'b0)
      stop_bus;
      addrHoldEn <= 1'b1;
      dataHoldEn <= 1'b1;
      i2ctr_master_model_i.bus_start;
      settle(8);
      byte_out(HI);
      `CHK(clockRelease, 1'b0)
      service;
      sw(3'h4);
      wr_addr(LO);
      `CHK(sclOe, 1'b0)
      byte_out(LO);
      `CHK(sclOe, 1'b1)
      sw(3'h4);
      byte_out(8'h69);
      `CHK(clockRelease, 1'b0)
      `CHK(sclOe, 1'b1)
      sw(3'h4);
      stop_bus;
      `CHK(stuck, 1'b0)
      wrap_up;
   end
endmodule
